// file: ttu_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "ttu_params.svh"

// one down counter with its waveform logic
module ttu_counter
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// configuration
	input wire logic [`TTU_CTL_WIDTH-1:0] ctrl,
	input wire logic [15:0] latch,
	input wire logic reload,
	input wire logic has_prescaler,
	// synchronised external pins
	input wire logic ext_tick,
	input wire logic gate_level,
	input wire logic gate_edge,
	// results
	output logic [15:0] count,
	output logic timeout,
	output logic wave
);

	typedef struct packed
	{
		logic [15:0] cnt;
		logic [2:0] pre;
		logic wave;
		logic armed;
		logic to;
	} ttu_cnt_s;

	ttu_cnt_s st_q;
	ttu_cnt_s st_d;
	logic src_tick;
	logic tick;
	logic trig_mode;
	ttu_pkg::ttu_mode_e mode;

	assign mode = ttu_pkg::ttu_mode_e'(ctrl[`TTU_CTL_MODE_HI:`TTU_CTL_MODE_LO]);
	assign trig_mode = ctrl[`TTU_CTL_GATE_TRIG];

	always_comb
	begin
		st_d = st_q;
		st_d.to = 1'b0;
		src_tick = ctrl[`TTU_CTL_EXT_CLK] ? ext_tick : 1'b1;
		if (!trig_mode && mode != ttu_pkg::TTU_MODE_COMPARE && !gate_level)
			src_tick = 1'b0;
		tick = src_tick;
		if (has_prescaler && ctrl[`TTU_CTL_PRESCALE])
		begin
			tick = 1'b0;
			if (src_tick)
			begin
				st_d.pre = st_q.pre - 3'h1;
				tick = (st_q.pre == 3'h0);
			end
		end
		if (mode == ttu_pkg::TTU_MODE_COMPARE)
			tick = tick & gate_level;
		if (reload || (trig_mode && gate_edge))
		begin
			st_d.cnt = latch;
			st_d.pre = `TTU_PRESCALE_DIV;
			st_d.armed = 1'b1;
			if (mode != ttu_pkg::TTU_MODE_SQUARE)
				st_d.wave = 1'b0;
			if (mode == ttu_pkg::TTU_MODE_PULSE)
				st_d.wave = 1'b1;
		end
		else if (ctrl[`TTU_CTL_RUN] && tick && st_q.armed)
		begin
			if (st_q.cnt == 16'h0000)
			begin
				st_d.to = 1'b1;
				st_d.cnt = latch;
				case (mode)
					ttu_pkg::TTU_MODE_SQUARE:
						st_d.wave = ~st_q.wave;
					ttu_pkg::TTU_MODE_DELAY:
					begin
						st_d.wave = 1'b1;
						st_d.armed = 1'b0;
					end
					ttu_pkg::TTU_MODE_PULSE:
					begin
						st_d.wave = 1'b0;
						st_d.armed = 1'b0;
					end
					default:
						st_d.armed = 1'b0;
				endcase
			end
			else
				st_d.cnt = st_q.cnt - 16'h0001;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			st_q <= {16'hFFFF, 3'h7, 1'b0, 1'b1, 1'b0};
		else
			st_q <= st_d;
	end

	assign count = st_q.cnt;
	assign timeout = st_q.to;
	assign wave = st_q.wave;

endmodule // ttu_counter

`default_nettype wire

// file: ttu_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side: one classic bus cycle at a time
module ttu_host_model
(
	// bus clock
	input wire logic clock,
	// request
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	// answer
	input wire logic [31:0] rdat,
	input wire logic ack,
	input wire logic err
);
	initial
	begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0;
	end

	// ----------------------------------------
	// bus cycle
	// ----------------------------------------
	// held until answer
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= d;
		// no cycle count assumed; the bench watchdog ends a hang
		do @(posedge clock);
		while (!(ack || err));
		q = rdat;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		dat <= ~d;
	endtask
endmodule // ttu_host_model

`default_nettype wire

// file: ttu_params.svh
`ifndef TTU_PARAMS_SVH
`define TTU_PARAMS_SVH

// ----------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------
`define TTU_CTRL0_OFS 8'h00
`define TTU_CTRL1_OFS 8'h04
`define TTU_CTRL2_OFS 8'h08
`define TTU_LATCH0_OFS 8'h0C
`define TTU_LATCH1_OFS 8'h10
`define TTU_LATCH2_OFS 8'h14
`define TTU_COUNT0_OFS 8'h18
`define TTU_COUNT1_OFS 8'h1C
`define TTU_COUNT2_OFS 8'h20
`define TTU_STATUS_OFS 8'h24
`define TTU_IRQ_EN_OFS 8'h28
`define TTU_IRQ_CLR_OFS 8'h2C

// ----------------------------------------
// control register fields
// ----------------------------------------
`define TTU_CTL_EXT_CLK 0
`define TTU_CTL_OUT_EN 1
`define TTU_CTL_MODE_LO 2
`define TTU_CTL_MODE_HI 3
`define TTU_CTL_GATE_TRIG 4
`define TTU_CTL_PRESCALE 5
`define TTU_CTL_RUN 6
`define TTU_CTL_WIDTH 7

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define TTU_CTRL_RST 7'h00
`define TTU_LATCH_RST 16'hFFFF
`define TTU_PRESCALE_DIV 3'h7

`endif

// file: ttu_pkg.sv
package ttu_pkg;

	typedef enum logic [1:0]
	{
		TTU_MODE_SQUARE = 2'b00,
		TTU_MODE_DELAY = 2'b01,
		TTU_MODE_PULSE = 2'b10,
		TTU_MODE_COMPARE = 2'b11
	} ttu_mode_e;

	typedef logic [15:0] ttu_count_t;

endpackage

// file: ttu_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser with falling-edge strobe taken after stage two
module ttu_sync
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// raw active-low input
	input wire logic in_n,
	// synchronised level (active high) and assertion strobe
	output logic level,
	output logic assert_pulse
);

	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
	} ttu_sync_s;

	ttu_sync_s st_q;
	ttu_sync_s st_d;

	always_comb
	begin
		st_d = st_q;
		st_d.s1 = in_n;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			st_q <= 3'h7;
		else
			st_q <= st_d;
	end

	assign level = ~st_q.s2;
	assign assert_pulse = st_q.s3 & ~st_q.s2;

endmodule // ttu_sync

`default_nettype wire

// file: ttu_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ttu_params.svh"

module ttu_top
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// timer pins
	input wire logic [2:0] timer_ext_clock_n,
	input wire logic [2:0] timer_gate_n,
	output logic [2:0] timer_out,
	// interrupt
	output logic irq
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed
	{
		logic [2:0][`TTU_CTL_WIDTH-1:0] ctrl;
		logic [2:0][15:0] latch;
		logic [2:0] status;
		logic [2:0] irq_en;
		logic [2:0] reload;
		logic [31:0] rdata;
		logic ack;
		logic err;
		logic [2:0] out;
	} ttu_top_s;

	ttu_top_s st_q;
	ttu_top_s st_d;

	logic [2:0] clk_lvl;
	logic [2:0] clk_edge;
	logic [2:0] gate_lvl;
	logic [2:0] gate_edge;
	logic [2:0][15:0] count;
	logic [2:0] timeout;
	logic [2:0] wave;
	logic req;
	logic wr;
	logic hit;
	logic [31:0] rd_val;

	// ----------------------------------------
	// per-timer synchronisers and counters
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_timer
			ttu_sync u_clk_sync
			(
				.clock(clock),
				.nrst(nrst),
				.in_n(timer_ext_clock_n[gi]),
				.level(clk_lvl[gi]),
				.assert_pulse(clk_edge[gi])
			);
			ttu_sync u_gate_sync
			(
				.clock(clock),
				.nrst(nrst),
				.in_n(timer_gate_n[gi]),
				.level(gate_lvl[gi]),
				.assert_pulse(gate_edge[gi])
			);
			ttu_counter u_cnt
			(
				.clock(clock),
				.nrst(nrst),
				.ctrl(st_q.ctrl[gi]),
				.latch(st_q.latch[gi]),
				.reload(st_q.reload[gi]),
				.has_prescaler(gi == 2),
				.ext_tick(clk_edge[gi]),
				.gate_level(gate_lvl[gi]),
				.gate_edge(gate_edge[gi]),
				.count(count[gi]),
				.timeout(timeout[gi]),
				.wave(wave[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	// single-cycle ack; ack drops after one cycle so back-to-back reads re-ack
	assign req = wb_cyc_i & wb_stb_i & ~st_q.ack & ~st_q.err;
	assign wr = req & wb_we_i & wb_sel_i[0];

	always_comb
	begin
		hit = 1'b1;
		rd_val = 32'h00000000;
		case (wb_adr_i)
			`TTU_CTRL0_OFS: rd_val = {25'h0, st_q.ctrl[0]};
			`TTU_CTRL1_OFS: rd_val = {25'h0, st_q.ctrl[1]};
			`TTU_CTRL2_OFS: rd_val = {25'h0, st_q.ctrl[2]};
			`TTU_LATCH0_OFS: rd_val = {16'h0, st_q.latch[0]};
			`TTU_LATCH1_OFS: rd_val = {16'h0, st_q.latch[1]};
			`TTU_LATCH2_OFS: rd_val = {16'h0, st_q.latch[2]};
			`TTU_COUNT0_OFS: rd_val = {16'h0, count[0]};
			`TTU_COUNT1_OFS: rd_val = {16'h0, count[1]};
			`TTU_COUNT2_OFS: rd_val = {16'h0, count[2]};
			`TTU_STATUS_OFS: rd_val = {29'h0, st_q.status};
			`TTU_IRQ_EN_OFS: rd_val = {29'h0, st_q.irq_en};
			`TTU_IRQ_CLR_OFS: rd_val = 32'h00000000;
			default: hit = 1'b0;
		endcase
	end

	always_comb
	begin
		st_d = st_q;
		st_d.reload = 3'h0;
		st_d.ack = 1'b0;
		st_d.err = 1'b0;
		if (req)
		begin
			st_d.ack = hit;
			st_d.err = ~hit;
			st_d.rdata = hit ? rd_val : 32'h00000000;
		end
		if (wr && hit)
		begin
			case (wb_adr_i)
				`TTU_CTRL0_OFS: st_d.ctrl[0] = wb_dat_i[`TTU_CTL_WIDTH-1:0];
				`TTU_CTRL1_OFS: st_d.ctrl[1] = wb_dat_i[`TTU_CTL_WIDTH-1:0];
				`TTU_CTRL2_OFS: st_d.ctrl[2] = wb_dat_i[`TTU_CTL_WIDTH-1:0];
				`TTU_IRQ_EN_OFS: st_d.irq_en = wb_dat_i[2:0];
				`TTU_IRQ_CLR_OFS: st_d.status = st_q.status & ~wb_dat_i[2:0];
				default: ;
			endcase
		end
		if (req && wb_we_i && hit)
		begin
			case (wb_adr_i)
				`TTU_LATCH0_OFS:
				begin
					st_d.latch[0] = {wb_sel_i[1] ? wb_dat_i[15:8] : st_q.latch[0][15:8],
						wb_sel_i[0] ? wb_dat_i[7:0] : st_q.latch[0][7:0]};
					st_d.reload[0] = 1'b1;
				end
				`TTU_LATCH1_OFS:
				begin
					st_d.latch[1] = {wb_sel_i[1] ? wb_dat_i[15:8] : st_q.latch[1][15:8],
						wb_sel_i[0] ? wb_dat_i[7:0] : st_q.latch[1][7:0]};
					st_d.reload[1] = 1'b1;
				end
				`TTU_LATCH2_OFS:
				begin
					st_d.latch[2] = {wb_sel_i[1] ? wb_dat_i[15:8] : st_q.latch[2][15:8],
						wb_sel_i[0] ? wb_dat_i[7:0] : st_q.latch[2][7:0]};
					st_d.reload[2] = 1'b1;
				end
				default: ;
			endcase
		end
		// timeout sets sticky flag, set beats clear
		st_d.status = st_d.status | timeout;
		for (int i = 0; i < 3; i++)
			st_d.out[i] = wave[i] & st_q.ctrl[i][`TTU_CTL_OUT_EN];
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q.ctrl <= {3{`TTU_CTRL_RST}};
			st_q.latch <= {3{`TTU_LATCH_RST}};
			st_q.status <= 3'h0;
			st_q.irq_en <= 3'h0;
			st_q.reload <= 3'h0;
			st_q.rdata <= 32'h00000000;
			st_q.ack <= 1'b0;
			st_q.err <= 1'b0;
			st_q.out <= 3'h0;
		end
		else
			st_q <= st_d;
	end

	assign wb_dat_o = st_q.rdata;
	assign wb_ack_o = st_q.ack;
	assign wb_err_o = st_q.err;
	assign timer_out = st_q.out;
	assign irq = |(st_q.status & st_q.irq_en);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_ack_one_cycle: assert property (@(posedge clock) disable iff (!nrst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held more than one cycle");
	a_ack_after_req: assert property (@(posedge clock) disable iff (!nrst)
		(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o) |=> (wb_ack_o || wb_err_o))
		else $error("request not answered next cycle");
	a_status_sticky: assert property (@(posedge clock) disable iff (!nrst)
		timeout[0] |=> st_q.status[0])
		else $error("timeout did not set status");
	a_irq_level: assert property (@(posedge clock) disable iff (!nrst)
		irq == |(st_q.status & st_q.irq_en))
		else $error("irq does not match enabled status");
	a_out_masked: assert property (@(posedge clock) disable iff (!nrst)
		!st_q.ctrl[1][`TTU_CTL_OUT_EN] |=> !timer_out[1])
		else $error("masked output is high");
	a_count_down: assert property (@(posedge clock) disable iff (!nrst)
		(st_q.ctrl[0][`TTU_CTL_RUN] && !st_q.ctrl[0][`TTU_CTL_EXT_CLK]
		&& st_q.ctrl[0][`TTU_CTL_GATE_TRIG] && !st_q.reload[0] && !gate_edge[0]
		&& st_q.ctrl[0][`TTU_CTL_MODE_HI:`TTU_CTL_MODE_LO] == 2'b00 && count[0] != 16'h0000)
		|=> count[0] == $past(count[0]) - 16'h0001)
		else $error("counter did not decrement");
	a_reload_latch: assert property (@(posedge clock) disable iff (!nrst)
		st_q.reload[2] |=> count[2] == $past(st_q.latch[2]))
		else $error("latch write did not reload counter");
	a_ext_sync: assert property (@(posedge clock) disable iff (!nrst)
		$fell(timer_ext_clock_n[2]) ##1 !timer_ext_clock_n[2] |=> clk_edge[2])
		else $error("external clock edge not seen after sync");

	a_ack_err_excl: assert property (@(posedge clock) disable iff (!nrst)
		!(wb_ack_o && wb_err_o))
		else $error("ack and err raised together");

	a_upper_zero: assert property (@(posedge clock) disable iff (!nrst)
		wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read data bits not zero");

	// ----------------------------------------
	// per-timer checks
	// ----------------------------------------
	genvar gc;
	generate
		for (gc = 0; gc < 3; gc++)
		begin : g_chk
			a_flag_set: assert property (@(posedge clock) disable iff (!nrst)
				timeout[gc] |=> st_q.status[gc])
				else $error("timeout flag not set");

			a_flag_holds: assert property (@(posedge clock) disable iff (!nrst)
				(st_q.status[gc] && !(wr && wb_adr_i == `TTU_IRQ_CLR_OFS && wb_dat_i[gc]))
				|=> st_q.status[gc])
				else $error("status flag lost without clear");

			a_timeout_zero: assert property (@(posedge clock) disable iff (!nrst)
				timeout[gc] |-> $past(count[gc]) == 16'h0000)
				else $error("timeout without zero count");

			a_irq_from_flag: assert property (@(posedge clock) disable iff (!nrst)
				(st_q.status[gc] && st_q.irq_en[gc]) |-> irq)
				else $error("enabled flag did not raise irq");

			a_out_follows: assert property (@(posedge clock) disable iff (!nrst)
				1'b1 |=> timer_out[gc] == ($past(wave[gc])
				& $past(st_q.ctrl[gc][`TTU_CTL_OUT_EN])))
				else $error("output does not follow waveform");

			a_stopped_hold: assert property (@(posedge clock) disable iff (!nrst)
				(!st_q.ctrl[gc][`TTU_CTL_RUN] && !st_q.reload[gc]
				&& !(st_q.ctrl[gc][`TTU_CTL_GATE_TRIG] && gate_edge[gc]))
				|=> count[gc] == $past(count[gc]))
				else $error("stopped counter moved");

			a_ext_hold: assert property (@(posedge clock) disable iff (!nrst)
				(st_q.ctrl[gc][`TTU_CTL_EXT_CLK] && st_q.ctrl[gc][`TTU_CTL_GATE_TRIG]
				&& !clk_edge[gc] && !st_q.reload[gc] && !gate_edge[gc])
				|=> count[gc] == $past(count[gc]))
				else $error("counter moved without external edge");

			a_gate_sync: assert property (@(posedge clock) disable iff (!nrst)
				($fell(timer_gate_n[gc]) ##1 !timer_gate_n[gc]) |=> gate_edge[gc])
				else $error("gate edge not seen after sync");
		end
	endgenerate

	c_timeout0: cover property (@(posedge clock) disable iff (!nrst) timeout[0]);
	c_irq: cover property (@(posedge clock) disable iff (!nrst) $rose(irq));
	c_out2: cover property (@(posedge clock) disable iff (!nrst) $rose(timer_out[2]));
	c_err: cover property (@(posedge clock) disable iff (!nrst) wb_err_o);
	c_gate_trig: cover property (@(posedge clock) disable iff (!nrst) gate_edge[0]);

endmodule // ttu_top

`default_nettype wire

// file: ttu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ttu_params.svh"

module ttu_top_tb;
	logic clock;
	logic nrst;
	logic cyc, stb, we, ack, err, irq, e;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q, a;
	logic [2:0] ext_n, gate_n, tout;
	int fails, samples_checked, n;

	initial clock = 1'b0;
	always #10 clock = ~clock;

	ttu_top u_dut(.clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.timer_ext_clock_n(ext_n), .timer_gate_n(gate_n), .timer_out(tout), .irq(irq));

	ttu_host_model u_host(.clock(clock), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat(wdat), .rdat(rdat), .ack(ack), .err(err));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		u_host.xfer(1'b1, ad, d, q, e);
	endtask

	task automatic rd(input logic [7:0] ad);
		u_host.xfer(1'b0, ad, 32'h0, q, e);
	endtask

	task automatic toggles();
		logic p;
		n = 0;
		p = tout[0];
		repeat (40)
		begin
			@(posedge clock);
			if (tout[0] !== p)
				n++;
			p = tout[0];
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		// reset state read before any setup
		rd(`TTU_COUNT0_OFS);
		chk(q, 32'h0000FFFF);
		rd(`TTU_STATUS_OFS);
		chk(q, 32'h0);
		rd(`TTU_CTRL0_OFS);
		chk(q, 32'h0);
		chk({tout, irq}, 4'h0);
		rd(8'h30);
		chk(e, 1'b1);
	endtask

	task automatic t_square_irq();
		wr(`TTU_LATCH0_OFS, 32'h3);
		// trigger mode, so an idle gate does not stall the count
		wr(`TTU_CTRL0_OFS, 32'h52);
		toggles();
		chk(n inside {9, 10, 11}, 1'b1);
		rd(`TTU_STATUS_OFS);
		chk(q, 32'h1);
		chk(irq, 1'b0);
		wr(`TTU_IRQ_EN_OFS, 32'h1);
		@(posedge clock);
		chk(irq, 1'b1);
		wr(`TTU_CTRL0_OFS, 32'h0);
		wr(`TTU_IRQ_CLR_OFS, 32'h1);
		rd(`TTU_STATUS_OFS);
		chk(q, 32'h0);
		chk(irq, 1'b0);
	endtask

	task automatic t_mask();
		wr(`TTU_LATCH0_OFS, 32'h3);
		wr(`TTU_CTRL0_OFS, 32'h50);
		toggles();
		chk(n, 0);
		chk(irq, 1'b1);
		wr(`TTU_CTRL0_OFS, 32'h0);
		wr(`TTU_IRQ_EN_OFS, 32'h0);
		wr(`TTU_IRQ_CLR_OFS, 32'h1);
	endtask

	task automatic t_count_down();
		wr(`TTU_LATCH1_OFS, 32'h100);
		wr(`TTU_CTRL1_OFS, 32'h50);
		rd(`TTU_COUNT1_OFS);
		a = q;
		rd(`TTU_COUNT1_OFS);
		chk(a < 32'h100 && q < a, 1'b1);
		wr(`TTU_CTRL1_OFS, 32'h0);
		wr(`TTU_IRQ_CLR_OFS, 32'h7);
	endtask

	task automatic t_ext_clock();
		wr(`TTU_LATCH2_OFS, 32'h2);
		wr(`TTU_CTRL2_OFS, 32'h51);
		repeat (20) @(posedge clock);
		rd(`TTU_STATUS_OFS);
		chk(q, 32'h0);
		// bench edges stand in for a cascaded timer output
		// slow edges: each low and high level spans two clocks
		repeat (3)
		begin
			ext_n[2] <= 1'b0;
			repeat (2) @(posedge clock);
			ext_n[2] <= 1'b1;
			repeat (2) @(posedge clock);
		end
		repeat (6) @(posedge clock);
		rd(`TTU_STATUS_OFS);
		chk(q, 32'h4);
	endtask

	task automatic t_gate_trig();
		wr(`TTU_LATCH0_OFS, 32'h20);
		wr(`TTU_CTRL0_OFS, 32'h50);
		repeat (8) @(posedge clock);
		wr(`TTU_CTRL0_OFS, 32'h10);
		rd(`TTU_COUNT0_OFS);
		chk(q < 32'h20, 1'b1);
		gate_n[0] <= 1'b0;
		repeat (4) @(posedge clock);
		gate_n[0] <= 1'b1;
		rd(`TTU_COUNT0_OFS);
		chk(q, 32'h20);
		wr(`TTU_IRQ_CLR_OFS, 32'h7);
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		nrst = 1'b0;
		ext_n = 3'h7;
		gate_n = 3'h7;
		fails = 0;
		samples_checked = 0;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		t_square_irq();
		t_mask();
		t_count_down();
		t_ext_clock();
		t_gate_trig();
		tally_and_finish();
	end

	initial
	begin
		#(20 * 20000);
		fails++;
		tally_and_finish();
	end
endmodule // ttu_top_tb

`default_nettype wire
